//--- core/link_cap_pkg.sv
// Constants and carrier types for the link capability register bank
package link_cap_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int SEL_W  = 4;

  // Byte addresses
  localparam logic [ADDR_W-1:0] LINK_CAP_OFS  = 12'h04c;
  localparam logic [ADDR_W-1:0] LINK_CTL_OFS  = 12'h050;
  localparam logic [ADDR_W-1:0] CFG_LOCK_OFS  = 12'h060;

  // Capability field positions
  localparam int SPEED_LSB   = 0;
  localparam int SPEED_MSB   = 3;
  localparam int WIDTH_LSB   = 4;
  localparam int WIDTH_MSB   = 9;
  localparam int ASPM_LSB    = 10;
  localparam int ASPM_MSB    = 11;
  localparam int L0S_LSB     = 12;
  localparam int L0S_MSB     = 14;
  localparam int L1_LSB      = 15;
  localparam int L1_MSB      = 17;
  localparam int CLKPM_BIT   = 18;
  localparam int SDOWN_BIT   = 19;
  localparam int ACTREP_BIT  = 20;
  localparam int RSVD_LSB    = 21;
  localparam int RSVD_MSB    = 23;
  localparam int PORT_LSB    = 24;
  localparam int PORT_MSB    = 31;

  // Link control and unlock bit positions
  localparam int SHARED_CLK_BIT = 6;
  localparam int UNLOCK_BIT     = 0;

  // Field values
  localparam logic [3:0] SPEED_GEN1     = 4'h1;
  localparam logic [3:0] SPEED_GEN2     = 4'h2;
  localparam logic [1:0] ASPM_L0S_L1    = 2'h3;
  localparam logic [2:0] L0S_SEPARATE   = 3'h5;
  localparam logic [2:0] L0S_COMMON     = 3'h3;
  localparam logic [2:0] L1_LAT_RESET   = 3'h2;
  localparam logic       CLKPM_RESET    = 1'h0;
  localparam logic [2:0] RSVD_VALUE     = 3'h0;
  localparam logic [7:0] UPSTREAM_PORT  = 8'h00;

  typedef enum logic [5:0] {
    WIDTH_X1 = 6'h01,
    WIDTH_X2 = 6'h02
  } width_code_t;

  typedef struct packed {
    logic              cyc;
    logic              stb;
    logic              we;
    logic [SEL_W-1:0]  sel;
    logic [ADDR_W-1:0] adr;
    logic [DATA_W-1:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic              ack;
    logic [DATA_W-1:0] dat;
  } wb_rsp_t;

endpackage : link_cap_pkg

//--- core/level_sync.sv
// Two-flop synchroniser for levels entering the core clock domain
`timescale 1ns/100ps
module level_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta;

  // No reset: the pin level is caught by the consumer after release
  always_ff @(posedge clk_i) begin
    meta   <= async_i;
    sync_o <= meta;
  end

endmodule : level_sync

//--- core/pcie_link_capabilities_reg.sv
// Link capability register bank for one switch port, Wishbone slave
//
// Functional notes
// - Speed field reads fixed gen1 code
// - Width field loads port lane width at reset
// - Upstream port lets software narrow width
// - Reserved width code trains as one lane
// - Power state support reads constant three
// - Fast idle latency follows clock sharing
// - Shared clock taken from link control bit
// - Deep idle latency resets to two
// - Reference clock removal resets to zero, writable when unlocked
// - Surprise down capable resets set only downstream, writable on both
// - Link active reporting only downstream
// - Port index field reads port number
//
// Register access over Wishbone was left to the implementer.
`timescale 1ns/100ps
module pcie_link_capabilities_reg
  import link_cap_pkg::*;
#(
  parameter logic [7:0] PORT_INDEX = 8'h00
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire link_cap_pkg::wb_req_t wb_req_i,
  output link_cap_pkg::wb_rsp_t      wb_rsp_o,
  input  wire logic                  two_lane_port_i,
  output logic [5:0]                 train_width_o,
  output logic [3:0]                 train_speed_o,
  output logic                       shared_refclk_o,
  output logic [2:0]                 fast_idle_latency_o,
  output logic                       surprise_down_en_o,
  output logic                       link_active_report_en_o
);

  import link_cap_pkg::*;

  localparam logic IS_UPSTREAM = (PORT_INDEX == UPSTREAM_PORT);

  // Lane width pin is a board strap from outside the clock domain
  logic       two_lane_sync;
  logic       strap_pending;

  logic [5:0] max_width_field;
  logic [2:0] deep_idle_exit_latency;
  logic       refclk_removal_tolerance;
  logic       surprise_down_capable;
  logic       link_active_report_capable;
  logic       shared_refclk_flag;
  logic       config_unlock;

  logic [2:0]        fast_idle_exit_latency;
  logic [DATA_W-1:0] cap_word;
  logic [DATA_W-1:0] ctl_word;
  logic [DATA_W-1:0] lock_word;
  logic [DATA_W-1:0] byte_mask;
  logic [DATA_W-1:0] cap_merged;
  logic [DATA_W-1:0] ctl_merged;
  logic [DATA_W-1:0] lock_merged;
  logic [DATA_W-1:0] next_rdata;
  logic              access;
  logic              wr_cap;
  logic              wr_ctl;
  logic              wr_lock;
  logic              lock_open;
  logic [5:0]        next_width;

  level_sync #(
    .WIDTH (1)
  ) u_strap_sync (
    .clk_i   (clk_i),
    .async_i (two_lane_port_i),
    .sync_o  (two_lane_sync)
  );

  // Byte lanes selected by the bus
  generate
    for (genvar b = 0; b < SEL_W; b++) begin : g_lane
      assign byte_mask[b*8 +: 8] = {8{wb_req_i.sel[b]}};
    end
  endgenerate

  // A request is served in the cycle before its ack is raised
  assign access  = wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack;
  assign wr_cap  = access && wb_req_i.we && (wb_req_i.adr == LINK_CAP_OFS);
  assign wr_ctl  = access && wb_req_i.we && (wb_req_i.adr == LINK_CTL_OFS);
  assign wr_lock = access && wb_req_i.we && (wb_req_i.adr == CFG_LOCK_OFS);
  assign lock_open = config_unlock;

  assign cap_merged  = (cap_word & ~byte_mask)
                     | (wb_req_i.dat & byte_mask);
  assign ctl_merged  = (ctl_word & ~byte_mask)
                     | (wb_req_i.dat & byte_mask);
  assign lock_merged = (lock_word & ~byte_mask)
                     | (wb_req_i.dat & byte_mask);

  // Latency reported depends on the shared reference clock
  always_comb begin
    if (shared_refclk_flag) begin
      fast_idle_exit_latency = L0S_COMMON;
    end else begin
      fast_idle_exit_latency = L0S_SEPARATE;
    end
  end

  // Assembled capability word as software sees it
  always_comb begin
    cap_word = '0;
    cap_word[SPEED_MSB:SPEED_LSB] = SPEED_GEN1;
    cap_word[WIDTH_MSB:WIDTH_LSB] = max_width_field;
    cap_word[ASPM_MSB:ASPM_LSB]   = ASPM_L0S_L1;
    cap_word[L0S_MSB:L0S_LSB]     = fast_idle_exit_latency;
    cap_word[L1_MSB:L1_LSB]       = deep_idle_exit_latency;
    cap_word[CLKPM_BIT]           = refclk_removal_tolerance;
    cap_word[SDOWN_BIT]           = surprise_down_capable;
    cap_word[ACTREP_BIT]          = link_active_report_capable;
    cap_word[RSVD_MSB:RSVD_LSB]   = RSVD_VALUE;
    cap_word[PORT_MSB:PORT_LSB]   = PORT_INDEX;
  end

  always_comb begin
    ctl_word = '0;
    ctl_word[SHARED_CLK_BIT] = shared_refclk_flag;
  end

  always_comb begin
    lock_word = '0;
    lock_word[UNLOCK_BIT] = config_unlock;
  end

  // Strap is sampled once, on the first edge after reset release
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strap_pending <= 1'b1;
    end else begin
      strap_pending <= 1'b0;
    end
  end

  // Width: hardware default from strap, upstream software may write any code when unlocked
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      max_width_field <= WIDTH_X1;
    end else if (strap_pending) begin
      max_width_field <= two_lane_sync ? WIDTH_X2 : WIDTH_X1;
    end else if (wr_cap && IS_UPSTREAM && lock_open) begin
      max_width_field <= cap_merged[WIDTH_MSB:WIDTH_LSB];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      deep_idle_exit_latency <= L1_LAT_RESET;
    end else if (wr_cap && lock_open) begin
      deep_idle_exit_latency <= cap_merged[L1_MSB:L1_LSB];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      refclk_removal_tolerance <= CLKPM_RESET;
    end else if (wr_cap && lock_open) begin
      refclk_removal_tolerance <= cap_merged[CLKPM_BIT];
    end
  end

  // Upstream may still be written; keeping it zero is software's job
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      surprise_down_capable <= !IS_UPSTREAM;
    end else if (wr_cap && lock_open) begin
      surprise_down_capable <= cap_merged[SDOWN_BIT];
    end
  end

  // Held at zero upstream whatever software writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link_active_report_capable <= !IS_UPSTREAM;
    end else if (wr_cap && lock_open && !IS_UPSTREAM) begin
      link_active_report_capable <= cap_merged[ACTREP_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shared_refclk_flag <= 1'b0;
    end else if (wr_ctl) begin
      shared_refclk_flag <= ctl_merged[SHARED_CLK_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      config_unlock <= 1'b0;
    end else if (wr_lock) begin
      config_unlock <= lock_merged[UNLOCK_BIT];
    end
  end

  // Read data selection; unmapped addresses answer zero
  always_comb begin
    unique case (wb_req_i.adr)
      LINK_CAP_OFS: next_rdata = cap_word;
      LINK_CTL_OFS: next_rdata = ctl_word;
      CFG_LOCK_OFS: next_rdata = lock_word;
      default:      next_rdata = '0;
    endcase
  end

  // One wait state: ack in the cycle after the strobe is seen
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_rsp_o <= '0;
    end else begin
      wb_rsp_o.ack <= access;
      if (access && !wb_req_i.we) begin
        wb_rsp_o.dat <= next_rdata;
      end else begin
        wb_rsp_o.dat <= '0;
      end
    end
  end

  // Reserved or unsupported width codes fall back to one lane
  always_comb begin
    unique case (max_width_field)
      WIDTH_X1: next_width = WIDTH_X1;
      WIDTH_X2: next_width = two_lane_sync ? WIDTH_X2 : WIDTH_X1;
      default:  next_width = WIDTH_X1;
    endcase
  end

  // Values handed to link training, all registered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      train_width_o <= WIDTH_X1;
    end else begin
      train_width_o <= next_width;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      train_speed_o <= SPEED_GEN1;
    end else begin
      train_speed_o <= SPEED_GEN1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shared_refclk_o <= 1'b0;
    end else begin
      shared_refclk_o <= shared_refclk_flag;
    end
  end

  // Follows the flag in the same cycle as the shared clock output
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fast_idle_latency_o <= L0S_SEPARATE;
    end else begin
      fast_idle_latency_o <= fast_idle_exit_latency;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      surprise_down_en_o <= 1'b0;
    end else begin
      surprise_down_en_o <= surprise_down_capable;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link_active_report_en_o <= 1'b0;
    end else begin
      link_active_report_en_o <= link_active_report_capable;
    end
  end

endmodule : pcie_link_capabilities_reg

//--- bench/link_cap_sva.sv
// Port assertions for the link capability register bank
`timescale 1ns/100ps
module link_cap_sva
  import link_cap_pkg::*;
#(
  parameter logic [7:0] PORT_INDEX = 8'h00
) (
  input wire logic                  clk_i,
  input wire logic                  rst_i,
  input wire link_cap_pkg::wb_req_t wb_req_i,
  input wire link_cap_pkg::wb_rsp_t wb_rsp_o,
  input wire logic                  two_lane_port_i,
  input wire logic [5:0]            train_width_o,
  input wire logic [3:0]            train_speed_o,
  input wire logic                  shared_refclk_o,
  input wire logic [2:0]            fast_idle_latency_o,
  input wire logic                  surprise_down_en_o,
  input wire logic                  link_active_report_en_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence cap_rd;
    wb_rsp_o.ack && !$past(wb_req_i.we) && $past(wb_req_i.adr) == LINK_CAP_OFS;
  endsequence
  a_speed_gen1: assert property (train_speed_o == SPEED_GEN1)
    else $error("speed output not gen1");
  a_width_legal: assert property (train_width_o inside {WIDTH_X1, WIDTH_X2})
    else $error("width output not one or two lanes");
  // Strap passes two flops and a register before the output
  a_one_lane_strap: assert property (!two_lane_port_i [*5] |->
    train_width_o == WIDTH_X1)
    else $error("one lane strap gave wide link");
  a_lat_common: assert property (shared_refclk_o [*3] |->
    fast_idle_latency_o == L0S_COMMON)
    else $error("latency not common clock value");
  a_lat_separate: assert property (!shared_refclk_o [*3] |->
    fast_idle_latency_o == L0S_SEPARATE)
    else $error("latency not separate clock value");
  a_actrep_up: assert property (PORT_INDEX != UPSTREAM_PORT ||
    !link_active_report_en_o)
    else $error("link active report set upstream");
  a_cap_fixed: assert property (cap_rd |-> wb_rsp_o.dat[11:10] == ASPM_L0S_L1
    && wb_rsp_o.dat[3:0] == SPEED_GEN1)
    else $error("fixed capability bits wrong");
  a_cap_rsvd: assert property (cap_rd |-> wb_rsp_o.dat[23:21] == RSVD_VALUE
    && wb_rsp_o.dat[31:24] == PORT_INDEX)
    else $error("reserved or port bits wrong");
  a_ack_once: assert property (wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack
    |=> wb_rsp_o.ack ##1 !wb_rsp_o.ack)
    else $error("ack not a single cycle answer");
endmodule : link_cap_sva
bind pcie_link_capabilities_reg link_cap_sva #(.PORT_INDEX(PORT_INDEX))
  i_link_cap_sva (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i),
  .wb_rsp_o(wb_rsp_o), .two_lane_port_i(two_lane_port_i),
  .train_width_o(train_width_o), .train_speed_o(train_speed_o),
  .shared_refclk_o(shared_refclk_o),
  .fast_idle_latency_o(fast_idle_latency_o),
  .surprise_down_en_o(surprise_down_en_o),
  .link_active_report_en_o(link_active_report_en_o));

//--- bench/pcie_link_capabilities_reg_test.sv
// Register level tests for the link capability register bank
`timescale 1ns/100ps
module pcie_link_capabilities_reg_test;
  import link_cap_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  wb_req_t     req = '0;
  wb_rsp_t     rsp;
  logic        two_lane = 1'b1;
  logic [5:0]  width_o;
  logic [3:0]  speed_o;
  logic        shared_o;
  logic [2:0]  lat_o;
  logic        sdown_o;
  logic        actrep_o;
  logic [31:0] rdat;
  wb_rsp_t     rsp_dn;
  logic        sdown_dn;
  logic        actrep_dn;
  logic [31:0] rdat_dn;
  int          fails = 0;
  int          samples_checked = 0;
  logic [5:0]  codes [5] = '{6'h00, 6'h01, 6'h02, 6'h08, 6'h3f};
  logic [5:0]  lanes [5] = '{6'h01, 6'h01, 6'h02, 6'h01, 6'h01};

  always #4 clk_i = ~clk_i;

  pcie_link_capabilities_reg #(.PORT_INDEX(UPSTREAM_PORT))
    i_pcie_link_capabilities_reg (.clk_i(clk_i), .rst_i(rst_i),
    .wb_req_i(req), .wb_rsp_o(rsp), .two_lane_port_i(two_lane),
    .train_width_o(width_o), .train_speed_o(speed_o),
    .shared_refclk_o(shared_o), .fast_idle_latency_o(lat_o),
    .surprise_down_en_o(sdown_o), .link_active_report_en_o(actrep_o));

  // Downstream port shares the bus request, answers on its own response
  pcie_link_capabilities_reg #(.PORT_INDEX(8'h02))
    i_pcie_link_capabilities_reg_dn (.clk_i(clk_i), .rst_i(rst_i),
    .wb_req_i(req), .wb_rsp_o(rsp_dn), .two_lane_port_i(two_lane),
    .train_width_o(), .train_speed_o(),
    .shared_refclk_o(), .fast_idle_latency_o(),
    .surprise_down_en_o(sdown_dn), .link_active_report_en_o(actrep_dn));

  task automatic check(input string nm, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // Entered just after a rising edge; leaves one idle cycle behind
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [3:0] s, input logic [31:0] d);
    int n;
    n = 0;
    req <= '{1'b1, 1'b1, w, s, a, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (rsp.ack !== 1'b1 && n < 50);
    rdat = rsp.dat;
    rdat_dn = rsp_dn.dat;
    req <= '0;
    @(posedge clk_i);
  endtask : bus

  task automatic rd(input string nm, input logic [11:0] a,
                    input logic [31:0] e);
    bus(1'b0, a, 4'hf, 32'h0);
    check(nm, rdat, e);
  endtask : rd

  // Outputs lag the register, so let them settle first
  task automatic outs(input logic [5:0] w, input logic [2:0] l,
                      input logic s);
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    check("train width", 32'(width_o), 32'(w));
    check("idle latency", 32'(lat_o), 32'(l));
    check("shared clock", 32'(shared_o), 32'(s));
    @(posedge clk_i);
  endtask : outs

  task automatic test_done;
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : test_done

  initial begin
    repeat (5000) @(posedge clk_i);
    fails++;
    test_done();
  end

  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rd("cap reset", LINK_CAP_OFS, 32'h0001_5c21);
    check("cap down reset", rdat_dn, 32'h0219_5c21);
    outs(WIDTH_X2, L0S_SEPARATE, 1'b0);
    check("speed", 32'(speed_o), 32'(SPEED_GEN1));
    check("sdown up", 32'(sdown_o), 32'h0);
    check("actrep up", 32'(actrep_o), 32'h0);
    check("sdown down", 32'(sdown_dn), 32'h1);
    check("actrep down", 32'(actrep_dn), 32'h1);
    $display("test reset done");
    bus(1'b1, LINK_CAP_OFS, 4'hf, 32'hffff_ffff);
    rd("cap locked", LINK_CAP_OFS, 32'h0001_5c21);
    rd("unmapped", 12'h100, 32'h0);
    $display("test lock done");
    bus(1'b1, CFG_LOCK_OFS, 4'h1, 32'h1);
    bus(1'b1, LINK_CAP_OFS, 4'hf, 32'hff3e_001f);
    rd("cap unlocked", LINK_CAP_OFS, 32'h000e_5c11);
    check("cap down unlocked", rdat_dn, 32'h021e_5c21);
    check("actrep up forced", 32'(actrep_o), 32'h0);
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, LINK_CAP_OFS, 4'h3, {22'h0, codes[i], 4'h0});
      outs(lanes[i], L0S_SEPARATE, 1'b0);
    end
    bus(1'b1, LINK_CAP_OFS, 4'h3, 32'h20);
    outs(WIDTH_X2, L0S_SEPARATE, 1'b0);
    two_lane <= 1'b0;
    outs(WIDTH_X1, L0S_SEPARATE, 1'b0);
    bus(1'b1, LINK_CAP_OFS, 4'h3, 32'h3f0);
    $display("test width done");
    bus(1'b1, LINK_CTL_OFS, 4'h1, 32'h40);
    rd("link control", LINK_CTL_OFS, 32'h40);
    rd("cap shared", LINK_CAP_OFS, 32'h000e_3ff1);
    outs(WIDTH_X1, L0S_COMMON, 1'b1);
    $display("test shared clock done");
    bus(1'b1, CFG_LOCK_OFS, 4'h1, 32'h0);
    bus(1'b1, LINK_CAP_OFS, 4'h3, 32'h20);
    rd("cap relocked", LINK_CAP_OFS, 32'h000e_3ff1);
    $display("test relock done");
    test_done();
  end
endmodule : pcie_link_capabilities_reg_test
